// file: hdl/mdsr_defs.vh
`ifndef MDSR_DEFS_VH
`define MDSR_DEFS_VH

// register indices of the status group
`define MDSR_REG_MODEL 16'h0000
`define MDSR_REG_VERSION 16'h0001
`define MDSR_REG_NODE 16'h0002
`define MDSR_REG_MODE 16'h0003
`define MDSR_REG_STATE 16'h0004
`define MDSR_REG_DIR 16'h0005
`define MDSR_REG_ERROR 16'h0006
`define MDSR_REG_MOTION 16'h0007

// drive mode encodings
`define MDSR_MODE_POS_SPEED 16'h0000
`define MDSR_MODE_HOMING 16'h0001
`define MDSR_MODE_TABLE 16'h0002

// motion status bit positions
`define MDSR_BIT_REACHED 0
`define MDSR_BIT_HOMED 1
`define MDSR_BIT_TURNING 2
`define MDSR_BIT_ALARM 3
`define MDSR_BIT_RELEASED 4
`define MDSR_BIT_SAME_POS 5
`define MDSR_RSVD_WIDTH 10

// error code limit
`define MDSR_ERR_MAX 3'h5

// identity values, arbitrary
`define MDSR_MODEL_ID 16'h1a2b
`define MDSR_VERSION_ID 16'h0010

`define MDSR_ZERO16 16'h0000
`define MDSR_ZERO3 3'h0

// zero padding that widens narrow status fields to a full word
`define MDSR_PAD15 15'h0000
`define MDSR_PAD13 13'h0000

`endif

// file: hdl/mdsr_status_regs.v
`timescale 1ns/1ps
`include "mdsr_defs.vh"

// Function
// RULE1: homing-complete terminal asserts once return-to-origin has finished.
// RULE2: motor-running terminal stays active while the motor turns.
// RULE3: in position mode, position-ready terminal asserts at commanded position.
// RULE4: table-mode-running terminal asserts while in multi-position table mode.
// RULE5: three segment output terminals, index 0..2, show multi-position state.
// RULE6: link is async half-duplex RTU, 8 data bits, default 8N1, 30 nodes.
// RULE7: status registers are read-only; bus writes never change them.
// RULE8: index 0x0000 returns a fixed 16-bit model code, high and low byte.
// RULE9: index 0x0002 returns the node number currently answered to.
// RULE10: index 0x0003 reports mode: 0 position/speed, 1 homing, 2 table.
// RULE11: index 0x0005 reports 0 counterclockwise, 1 clockwise.
// RULE12: index 0x0006 holds 0 normally, 1 to 5 for an active error.
// RULE13: motion status bit 0 set when target position reached.
// RULE14: motion status bit 1 set when return-to-origin completed.
// RULE15: motion status bit 2 reflects motor turning.
// RULE16: motion status bit 3 set during alarm.
// RULE17: motion status bit 4 set when motor released.
// RULE18: motion status bit 5 set when current equals commanded position.
// RULE19: motion status bits 6 to 15 read as zero.
module mdsr_status_regs (
  input wire i_clk,
  input wire i_resetn,
  // drive core status
  input wire [15:0] i_node_number,
  input wire i_mode_homing,
  input wire i_mode_table,
  input wire i_turning,
  input wire i_clockwise,
  input wire [2:0] i_error,
  input wire i_alarm,
  input wire i_released,
  input wire i_homing_done,
  input wire i_target_reached,
  input wire i_pos_equal,
  input wire [2:0] i_segment,
  // register access from the frame decoder
  input wire i_rd,
  input wire i_wr,
  input wire [15:0] i_addr,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  output reg o_rvalid,
  output reg o_rerr,
  output reg o_wack,
  output reg o_werr,
  // output terminals
  output reg o_homed,
  output reg o_running,
  output reg o_pos_ready,
  output reg o_table_running,
  output reg [2:0] o_segment_outputs
);

////////////////////////////////////////////////////////////////////////////////
// status capture

reg [15:0] node;
reg [15:0] mode;
reg turning;
reg clockwise;
reg [2:0] error;
reg [15:0] motion;
reg [15:0] next_mode;
reg [2:0] next_error;
reg [15:0] next_motion;

// table wins over homing, so a core that flags both is reported in table mode
always @* begin
  // RULE10 mode encode
  if (i_mode_table) begin
    next_mode = `MDSR_MODE_TABLE;
  end else if (i_mode_homing) begin
    next_mode = `MDSR_MODE_HOMING;
  end else begin
    next_mode = `MDSR_MODE_POS_SPEED;
  end
end

always @* begin
  // RULE12 error clamp; an out-of-range code still flags an error
  if (i_error > `MDSR_ERR_MAX) begin
    next_error = `MDSR_ERR_MAX;
  end else begin
    next_error = i_error;
  end
end

// reserved bits are tied low so a later field never reads as stale data
always @* begin
  next_motion = `MDSR_ZERO16;
  // RULE13 reached
  next_motion[`MDSR_BIT_REACHED] = i_target_reached;
  // RULE14 homing complete
  next_motion[`MDSR_BIT_HOMED] = i_homing_done;
  // RULE15 turning bit
  next_motion[`MDSR_BIT_TURNING] = i_turning;
  // RULE16 alarm bit
  next_motion[`MDSR_BIT_ALARM] = i_alarm;
  // RULE17 released bit
  next_motion[`MDSR_BIT_RELEASED] = i_released;
  // RULE18 same position
  next_motion[`MDSR_BIT_SAME_POS] = i_pos_equal;
  // RULE19 reserved bits keep the zero given above
end

// status is sampled every edge; the core drives levels, never pulses
always @(posedge i_clk) begin
  if (!i_resetn) begin
    node <= `MDSR_ZERO16;
  end else begin
    // RULE9 live node
    node <= i_node_number;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    mode <= `MDSR_MODE_POS_SPEED;
  end else begin
    // RULE10 mode word
    mode <= next_mode;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    turning <= 1'b0;
  end else begin
    // motor state word
    turning <= i_turning;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    clockwise <= 1'b0;
  end else begin
    // RULE11 direction
    clockwise <= i_clockwise;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    error <= `MDSR_ZERO3;
  end else begin
    // RULE12 error word
    error <= next_error;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    motion <= `MDSR_ZERO16;
  end else begin
    // RULE13 motion bits
    motion <= next_motion;
  end
end

////////////////////////////////////////////////////////////////////////////////
// output terminals

// each terminal follows its level one edge later, straight from a flop
reg next_homed;
reg next_running;
reg next_pos_ready;
reg next_table_running;
reg [2:0] next_segment;

always @* begin
  // RULE1 homed terminal
  next_homed = i_homing_done;
end

always @* begin
  // RULE2 running terminal
  next_running = i_turning;
end

always @* begin
  // RULE3 position-ready terminal, only outside homing and table modes
  next_pos_ready = i_target_reached & ~i_mode_homing & ~i_mode_table;
end

always @* begin
  // RULE4 table terminal
  next_table_running = i_mode_table;
end

// segments carry no meaning outside table mode, so they are parked low
always @* begin
  // RULE5 segment terminals
  next_segment = i_mode_table ? i_segment : `MDSR_ZERO3;
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_homed <= 1'b0;
  end else begin
    // RULE1 homed flop
    o_homed <= next_homed;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_running <= 1'b0;
  end else begin
    // RULE2 running flop
    o_running <= next_running;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_pos_ready <= 1'b0;
  end else begin
    // RULE3 ready flop
    o_pos_ready <= next_pos_ready;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_table_running <= 1'b0;
  end else begin
    // RULE4 table flop
    o_table_running <= next_table_running;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_segment_outputs <= `MDSR_ZERO3;
  end else begin
    // RULE5 segment flops
    o_segment_outputs <= next_segment;
  end
end

////////////////////////////////////////////////////////////////////////////////
// register read and write answer
// RULE6 framing sits in the frame decoder; one request here is one 16-bit word

reg [15:0] state_word;
reg [15:0] dir_word;
reg [15:0] error_word;
reg [15:0] next_rdata;
reg next_hit;
reg next_rerr;

// narrow status fields are zero-extended to a full word
always @* begin
  state_word = {`MDSR_PAD15, turning};
end

always @* begin
  // RULE11 direction word
  dir_word = {`MDSR_PAD15, clockwise};
end

always @* begin
  // RULE12 error word
  error_word = {`MDSR_PAD13, error};
end

always @* begin
  next_hit = 1'b1;
  case (i_addr)
    // RULE8 fixed model
    `MDSR_REG_MODEL: next_rdata = `MDSR_MODEL_ID;
    `MDSR_REG_VERSION: next_rdata = `MDSR_VERSION_ID;
    `MDSR_REG_NODE: next_rdata = node;
    `MDSR_REG_MODE: next_rdata = mode;
    `MDSR_REG_STATE: next_rdata = state_word;
    `MDSR_REG_DIR: next_rdata = dir_word;
    `MDSR_REG_ERROR: next_rdata = error_word;
    `MDSR_REG_MOTION: next_rdata = motion;
    // unmapped index reads as zero
    default: begin
      next_rdata = `MDSR_ZERO16;
      next_hit = 1'b0;
    end
  endcase
end

always @* begin
  next_rerr = i_rd & ~next_hit;
end

// a read sees status captured one edge earlier, so a word never tears
always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_rdata <= `MDSR_ZERO16;
  end else if (i_rd) begin
    o_rdata <= next_rdata;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_rvalid <= 1'b0;
  end else begin
    // RULE6 one answer per request
    o_rvalid <= i_rd;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_rerr <= 1'b0;
  end else begin
    // unmapped index flagged
    o_rerr <= next_rerr;
  end
end

// nothing here is writable, so every write is answered and refused
always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_wack <= 1'b0;
  end else begin
    // RULE7 write answered
    o_wack <= i_wr;
  end
end

always @(posedge i_clk) begin
  if (!i_resetn) begin
    o_werr <= 1'b0;
  end else begin
    // RULE7 writes refused; status unchanged, data ignored
    o_werr <= i_wr;
  end
end

endmodule

// file: tb/mdsr_master.sv
`timescale 1ns/1ps
module mdsr_master (
  input wire i_clk,
  output reg o_rd = 0,
  output reg o_wr = 0,
  output reg [15:0] o_addr = 0
);
  task access(input w, input [15:0] a);
    begin
      @(posedge i_clk);
      o_rd <= !w;
      o_wr <= w;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 0;
      o_wr <= 0;
      // released index never shows the last value
      o_addr <= ~a;
    end
  endtask
endmodule

// file: tb/mdsr_status_regs_assertions.sv
`timescale 1ns/1ps
`include "mdsr_defs.vh"
module mdsr_checker (
  input wire i_clk,
  input wire i_resetn,
  input wire i_rd,
  input wire i_wr,
  input wire [15:0] i_addr,
  input wire [15:0] i_node_number,
  input wire i_clockwise,
  input wire i_turning,
  input wire i_mode_table,
  input wire [2:0] i_segment,
  input wire [15:0] o_rdata,
  input wire o_rvalid,
  input wire o_rerr,
  input wire o_wack,
  input wire o_werr,
  input wire o_running,
  input wire o_table_running,
  input wire [2:0] o_segment_outputs
);
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  rd_answer_a: assert property (i_rd |=> o_rvalid && o_rerr == ($past(i_addr) > 16'h0007)) else $error("bad rd");
  wr_refused_a: assert property (i_wr |=> o_wack && o_werr) else $error("bad wr");
  model_code_a: assert property (i_rd && i_addr == 16'h0000 |=> o_rdata == `MDSR_MODEL_ID) else $error("bad id");
  node_read_a: assert property (i_rd && i_addr == 16'h0002 |=> o_rdata == $past(i_node_number, 2))
    else $error("bad node");
  dir_read_a: assert property (i_rd && i_addr == 16'h0005 |=> o_rdata == {15'h0000, $past(i_clockwise, 2)})
    else $error("bad dir");
  rsvd_zero_a: assert property (i_rd && i_addr == 16'h0007 |=> o_rdata[15:6] == 10'h000) else $error("bad rsvd");
  running_out_a: assert property (i_turning ##1 i_turning |-> o_running) else $error("bad run");
  table_out_a: assert property ($past(i_mode_table) |-> o_table_running && o_segment_outputs == $past(i_segment))
    else $error("bad table");
  cover property (i_rd && i_addr == 16'h0007);
  cover property (i_wr);
  cover property (o_table_running);
endmodule
bind mdsr_status_regs mdsr_checker chk_u (.*);

// file: tb/mdsr_status_regs_tb_top.sv
`timescale 1ns/1ps
`include "mdsr_defs.vh"
module mdsr_status_regs_tb_top;
  reg i_clk = 0, i_resetn = 0, i_mode_homing = 0, i_mode_table = 0, i_turning = 0, i_clockwise = 0;
  reg i_alarm = 0, i_released = 0, i_homing_done = 0, i_target_reached = 0, i_pos_equal = 0;
  reg [2:0] i_error = 0, i_segment = 0;
  reg [15:0] i_node_number = 0, i_wdata = 16'hffff;
  wire i_rd, i_wr, o_rvalid, o_rerr, o_wack, o_werr, o_homed, o_running, o_pos_ready, o_table_running;
  wire [15:0] i_addr, o_rdata;
  wire [2:0] o_segment_outputs;
  integer errors = 0, checks = 0;
  mdsr_status_regs dut (.*);
  mdsr_master master (.i_clk(i_clk), .o_rd(i_rd), .o_wr(i_wr), .o_addr(i_addr));
  initial forever #2 i_clk = ~i_clk;
  task chk(input [63:0] n, input [15:0] e, input [15:0] s);
    begin
      checks = checks + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("unexpected %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  task rd(input [15:0] a, input [15:0] e);
    begin
      master.access(0, a);
      #1;
      chk("rresp", {1'b1, a > 16'h0007}, {o_rvalid, o_rerr});
      chk("rdata", e, o_rdata);
    end
  endtask
  task t_status;
    begin
      @(posedge i_clk);
      i_node_number <= 16'h0015;
      {i_clockwise, i_turning, i_error} <= 5'h1b;
      {i_target_reached, i_homing_done, i_alarm, i_released, i_pos_equal} <= 5'h1f;
      repeat (2) @(posedge i_clk);
      rd(2, 16'h0015);
      rd(4, 1);
      rd(5, 1);
      rd(6, 3);
      rd(7, 16'h003f);
      $display("status done");
    end
  endtask
  task t_write;
    begin
      master.access(1, 2);
      #1;
      chk("wresp", 3, {o_wack, o_werr});
      rd(2, 16'h0015);
      rd(0, `MDSR_MODEL_ID);
      rd(1, `MDSR_VERSION_ID);
      rd(16'h0008, 0);
      $display("write done");
    end
  endtask
  task t_modes;
    integer m;
    begin
      for (m = 0; m < 3; m = m + 1) begin
        @(posedge i_clk);
        i_mode_homing <= m != 0;
        i_mode_table <= m == 2;
        i_segment <= 3'h5;
        i_turning <= m != 0;
        i_homing_done <= m == 2;
        i_error <= 3'h5 + m[2:0];
        repeat (2) @(posedge i_clk);
        rd(3, m);
        rd(6, 5);
        chk("table", m == 2 ? 16'h000d : 0, {o_table_running, o_segment_outputs});
        chk("ready", m == 0, o_pos_ready);
        chk("homerun", {m == 2, m != 0}, {o_homed, o_running});
      end
      $display("modes done");
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1;
    t_status;
    t_write;
    t_modes;
    summarize;
  end
endmodule
